// ### flck_consts.svh
`ifndef FLCK_CONSTS_SVH
`define FLCK_CONSTS_SVH

// Command codes seen on the low data byte of a write cycle
`define FLCK_CMD_LOCK_SETUP 8'h60
`define FLCK_CMD_LOCK 8'h01
`define FLCK_CMD_UNLOCK 8'hd0
`define FLCK_CMD_LOCKDOWN 8'h2f
`define FLCK_CMD_PROT_SETUP 8'hc0
`define FLCK_CMD_RCR_SET 8'h03
`define FLCK_CMD_READ_ARRAY 8'hff
`define FLCK_CMD_READ_STATUS 8'h70
`define FLCK_CMD_READ_ID 8'h90
`define FLCK_CMD_READ_QUERY 8'h98
`define FLCK_CMD_CLR_STATUS 8'h50

// Status flag layout and reset value
`define FLCK_SR_ERR_HI 5
`define FLCK_SR_ERR_LO 4
`define FLCK_SR_RESET 8'h80

// Read configuration fields and reset value
`define FLCK_RCR_MODE 15
`define FLCK_RCR_LC_HI 13
`define FLCK_RCR_LC_LO 11
`define FLCK_RCR_RESET 16'hbfcf
`define FLCK_LC_MIN 3'h2

// Block index inside the address, lock reset state
`define FLCK_BLK_HI 15
`define FLCK_BLK_LO 12
`define FLCK_LOCK_RESET 16'hffff

// Burst shape and identifier offsets
`define FLCK_BURST_LAST 2'h3
`define FLCK_ID_RCR_OFF 3'h5
// Identifier word: arbitrary value, no maker behind it
`define FLCK_ID_WORD 16'h00a5
`define FLCK_QUERY_WORD 16'h0000

// APB register byte offsets
`define FLCK_REG_STATUS 8'h00
`define FLCK_REG_RCR 8'h04
`define FLCK_REG_LOCK 8'h08
`define FLCK_REG_PROT 8'h0c
`define FLCK_REG_MEM_ADDR 8'h10
`define FLCK_REG_MEM_DATA 8'h14
`define FLCK_REG_STATE 8'h18

`endif

// ### flck_pkg.sv
package flck_pkg;
	// Command decoder progress
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_SETUP60 = 2'b01,
		C_PROT = 2'b10
	} flck_cmd_t;
	// Read state: what a read returns
	typedef enum logic [1:0] {
		R_ARRAY = 2'b00,
		R_ID = 2'b01,
		R_STATUS = 2'b10,
		R_QUERY = 2'b11
	} flck_rd_t;
	// Synchronous burst progress
	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_LAT = 2'b01,
		B_DATA = 2'b10,
		B_DONE = 2'b11
	} flck_burst_t;
endpackage

// ### flck_mem_if.sv
`timescale 1ns/100ps
interface flck_mem_if;
	logic we; // Word write strobe
	logic [5:0] waddr; // Word index
	logic [15:0] wdata; // Word to store
	logic [3:0] raddr; // Page index
	logic [63:0] rdata; // Four-word page, registered
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
	modport user (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// ### flck_mem.sv
`timescale 1ns/100ps
module flck_mem (
	// Clock
	input wire logic clk,
	// Array port
	flck_mem_if.mem mp
);
	// Array words, four to a page
	logic [15:0] mem_q [0:63];
	logic [63:0] rdata_q;

	// Word writes from the register bus
	always_ff @(posedge clk) begin
		if (mp.we) begin
			mem_q[mp.waddr] <= mp.wdata;
		end
	end

	// Whole page sensed at once into the page buffer
	always_ff @(posedge clk) begin
		rdata_q <= {mem_q[{mp.raddr, 2'b11}], mem_q[{mp.raddr, 2'b10}],
			mem_q[{mp.raddr, 2'b01}], mem_q[{mp.raddr, 2'b00}]};
	end

	assign mp.rdata = rdata_q;
endmodule // flck_mem

// ### flck_top.sv
`timescale 1ns/100ps
`include "flck_consts.svh"

// How it works
// - Lock setup accepts only lock, unlock, lock-down or set-config commands next
// - Lock code locks the addressed block
// - Unlock code unlocks unless locked down
// - Lock-down code locks block down
// - Protection setup, second write captured
// - Config setup needs set-config next
// - Set-config stores address, returns to array
// - Reset selects asynchronous page mode
// - Four read states, array after reset
// - Page reads only with mode bit set
// - Page mode: wait inactive, clock ignored
// - Low address bits pick page word
// - Burst address captured on valid rising, or on a clock edge with valid held low
// - First word after latency, then each edge
// - Non-array bursts repeat the same word
// - Mode bit: zero burst, one page
// - Latency code field, reset seven
module flck_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic addr_valid_n,
	input wire logic flash_clk,
	input wire logic [15:0] addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic wait_out
);
	import flck_pkg::*;

	flck_mem_if mif();
	flck_mem flck_mem_inst (.clk(mclk), .mp(mif));

	// Pin history for edge detection
	logic we_prev_q;
	logic avn_prev_q;
	logic fclk_prev_q;
	// Decoder and read state
	flck_cmd_t cmd_q;
	flck_rd_t rd_q;
	// Device state visible to software
	logic [7:0] status_q;
	logic [15:0] rcr_q;
	logic [15:0] locked_q;
	logic [15:0] lockdown_q;
	logic [15:0] prot_addr_q;
	logic [15:0] prot_data_q;
	// Read path
	logic [15:0] addr_lat_q;
	flck_burst_t b_q;
	logic [2:0] lat_cnt_q;
	logic [1:0] beats_q;
	logic [15:0] baddr_q;
	logic [5:0] mem_idx_q;
	// Decoded events
	logic cmd_stb;
	logic [7:0] code;
	logic [3:0] blk;
	logic seq_err;
	logic clr_err;
	logic sync_mode;
	logic fclk_edge;
	logic avn_rise;
	logic capture;
	logic beat;
	logic [2:0] lat_eff;
	logic apb_wr;
	logic [15:0] page_word;
	logic [15:0] burst_word;

	// Page word picked by the low address bits, or a non-array word
	function automatic logic [15:0] read_word(input logic [15:0] a);
		logic [15:0] w;
		w = 16'h0000;
		unique case (rd_q)
			R_ARRAY: w = mif.rdata[{a[1:0], 4'h0} +: 16];
			R_STATUS: w = {8'h00, status_q};
			R_ID: w = (a[2:0] == `FLCK_ID_RCR_OFF) ? rcr_q : `FLCK_ID_WORD;
			R_QUERY: w = `FLCK_QUERY_WORD;
		endcase
		return w;
	endfunction

	// Command write completes on the rising of write enable
	assign cmd_stb = ~ce_n & ~we_prev_q & we_n;
	assign code = dq_in[7:0];
	assign blk = addr[`FLCK_BLK_HI:`FLCK_BLK_LO];
	assign seq_err = cmd_stb & (cmd_q == C_SETUP60) & (code != `FLCK_CMD_LOCK) &
		(code != `FLCK_CMD_UNLOCK) & (code != `FLCK_CMD_LOCKDOWN) &
		(code != `FLCK_CMD_RCR_SET);
	assign apb_wr = psel & penable & pready & pwrite;
	assign clr_err = (cmd_stb & (cmd_q == C_IDLE) & (code == `FLCK_CMD_CLR_STATUS)) |
		(apb_wr & (paddr == `FLCK_REG_STATUS));
	// Clock input only matters in burst mode
	assign sync_mode = ~rcr_q[`FLCK_RCR_MODE];
	assign fclk_edge = flash_clk & ~fclk_prev_q;
	assign avn_rise = addr_valid_n & ~avn_prev_q;
	// Rising valid, or a clock edge with valid still held low
	assign capture = sync_mode & ~ce_n &
		(avn_rise | (fclk_edge & ~addr_valid_n & (b_q == B_IDLE)));
	// Reserved latency codes below two act as two
	assign lat_eff = (rcr_q[`FLCK_RCR_LC_HI:`FLCK_RCR_LC_LO] < `FLCK_LC_MIN) ?
		`FLCK_LC_MIN : rcr_q[`FLCK_RCR_LC_HI:`FLCK_RCR_LC_LO];
	assign beat = fclk_edge & ~ce_n &
		(((b_q == B_LAT) & (lat_cnt_q == 3'h1)) | (b_q == B_DATA));
	// Process, not assign: the word also moves with page data and read state
	always_comb begin
		page_word = read_word(addr_lat_q);
		burst_word = read_word(baddr_q);
	end

	// Array fetch address follows the active read mode
	assign mif.raddr = sync_mode ? baddr_q[5:2] : addr_lat_q[5:2];
	assign mif.we = apb_wr & (paddr == `FLCK_REG_MEM_DATA);
	assign mif.waddr = mem_idx_q;
	assign mif.wdata = pwdata[15:0];

	// Pin history
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			we_prev_q <= 1'b1;
			avn_prev_q <= 1'b1;
			fclk_prev_q <= 1'b1;
		end else begin
			we_prev_q <= we_n;
			avn_prev_q <= addr_valid_n;
			fclk_prev_q <= flash_clk;
		end
	end

	// Two-cycle command decoder
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmd_q <= C_IDLE;
		end else if (cmd_stb) begin
			unique case (cmd_q)
				C_IDLE: begin
					if (code == `FLCK_CMD_LOCK_SETUP) begin
						cmd_q <= C_SETUP60;
					end else if (code == `FLCK_CMD_PROT_SETUP) begin
						cmd_q <= C_PROT;
					end
				end
				// Any second cycle closes the pair
				C_SETUP60, C_PROT: cmd_q <= C_IDLE;
				default: cmd_q <= C_IDLE;
			endcase
		end
	end

	// Status flags; an error in the clearing cycle still lands
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			status_q <= `FLCK_SR_RESET;
		end else begin
			if (clr_err) begin
				status_q[`FLCK_SR_ERR_HI:`FLCK_SR_ERR_LO] <= 2'b00;
			end
			if (seq_err) begin
				status_q[`FLCK_SR_ERR_HI:`FLCK_SR_ERR_LO] <= 2'b11;
			end
		end
	end

	// Block lock bits
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			locked_q <= `FLCK_LOCK_RESET;
			lockdown_q <= 16'h0000;
		end else if (cmd_stb && cmd_q == C_SETUP60) begin
			if (code == `FLCK_CMD_LOCK) begin
				locked_q[blk] <= 1'b1;
			end else if (code == `FLCK_CMD_UNLOCK) begin
				// Locked-down blocks ignore unlock
				if (!lockdown_q[blk]) begin
					locked_q[blk] <= 1'b0;
				end
			end else if (code == `FLCK_CMD_LOCKDOWN) begin
				locked_q[blk] <= 1'b1;
				lockdown_q[blk] <= 1'b1;
			end
		end
	end

	// Read configuration register, reset to page mode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rcr_q <= `FLCK_RCR_RESET;
		end else if (cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_RCR_SET) begin
			rcr_q <= addr;
		end
	end

	// Protection program: second write latched into address and data
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prot_addr_q <= 16'h0000;
			prot_data_q <= 16'h0000;
		end else if (cmd_stb && cmd_q == C_PROT) begin
			prot_addr_q <= addr;
			prot_data_q <= dq_in;
		end
	end

	// Read state changes only on read commands and set-config
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= R_ARRAY;
		end else if (cmd_stb && cmd_q == C_IDLE) begin
			if (code == `FLCK_CMD_READ_ARRAY) begin
				rd_q <= R_ARRAY;
			end else if (code == `FLCK_CMD_READ_STATUS) begin
				rd_q <= R_STATUS;
			end else if (code == `FLCK_CMD_READ_ID) begin
				rd_q <= R_ID;
			end else if (code == `FLCK_CMD_READ_QUERY) begin
				rd_q <= R_QUERY;
			end
		end else if (cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_RCR_SET) begin
			rd_q <= R_ARRAY;
		end
	end

	// Address follows the pins while valid is low, holds after
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addr_lat_q <= 16'h0000;
		end else if (!addr_valid_n) begin
			addr_lat_q <= addr;
		end
	end

	// Burst sequencer; clock edges count only in burst mode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			b_q <= B_IDLE;
			lat_cnt_q <= 3'h0;
			beats_q <= 2'h0;
			baddr_q <= 16'h0000;
		end else if (ce_n || !sync_mode) begin
			b_q <= B_IDLE;
		end else if (capture) begin
			b_q <= B_LAT;
			lat_cnt_q <= lat_eff;
			beats_q <= 2'h0;
			baddr_q <= avn_rise ? addr_lat_q : addr;
		end else if (fclk_edge) begin
			unique case (b_q)
				B_IDLE, B_DONE: b_q <= b_q;
				B_LAT: begin
					lat_cnt_q <= lat_cnt_q - 3'h1;
					if (lat_cnt_q == 3'h1) begin
						b_q <= B_DATA;
					end
				end
				B_DATA: begin
					if (beats_q == `FLCK_BURST_LAST) begin
						b_q <= B_DONE;
					end
				end
			endcase
			if (beat) begin
				beats_q <= beats_q + 2'h1;
				// Linear through the array, fixed word otherwise
				if (rd_q == R_ARRAY) begin
					baddr_q <= baddr_q + 16'h0001;
				end
			end
		end
	end

	// Data pins: page word every cycle, burst word on each beat
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dq_out <= 16'h0000;
			dq_oe <= 1'b0;
			wait_out <= 1'b0;
		end else begin
			dq_oe <= ~ce_n & ~oe_n & we_n;
			if (!sync_mode) begin
				dq_out <= page_word;
				wait_out <= 1'b0;
			end else begin
				// Wait is active high while latency runs
				wait_out <= ~ce_n & (b_q == B_LAT);
				if (beat) begin
					dq_out <= burst_word;
				end
			end
		end
	end

	// APB index into the array for software loads
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mem_idx_q <= 6'h00;
		end else if (apb_wr && paddr == `FLCK_REG_MEM_ADDR) begin
			mem_idx_q <= pwdata[5:0];
		end else if (mif.we) begin
			mem_idx_q <= mem_idx_q + 6'h01;
		end
	end

	// APB answer: ready in the first access cycle, no waits
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable & ~pready;
			if (psel && !penable) begin
				pslverr <= 1'b0;
				unique case (paddr)
					`FLCK_REG_STATUS: prdata <= {24'h00_0000, status_q};
					`FLCK_REG_RCR: prdata <= {16'h0000, rcr_q};
					`FLCK_REG_LOCK: prdata <= {lockdown_q, locked_q};
					`FLCK_REG_PROT: prdata <= {prot_addr_q, prot_data_q};
					`FLCK_REG_MEM_ADDR: prdata <= {26'h000_0000, mem_idx_q};
					`FLCK_REG_MEM_DATA: prdata <= 32'h0000_0000;
					`FLCK_REG_STATE: prdata <= {26'h000_0000, b_q, rd_q, cmd_q};
					default: begin
						// Unmapped: zero data and an error
						prdata <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Bad second cycle after setup raises both error flags
	property p_seq_err;
		seq_err |=> status_q[`FLCK_SR_ERR_HI] && status_q[`FLCK_SR_ERR_LO];
	endproperty
	a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged");

	property p_lock;
		(cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_LOCK) |=> locked_q[$past(blk)];
	endproperty
	a_lock: assert property (p_lock) else $error("block not locked");

	property p_unlock;
		(cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_UNLOCK && !lockdown_q[blk])
			|=> !locked_q[$past(blk)];
	endproperty
	a_unlock: assert property (p_unlock) else $error("block not unlocked");

	property p_keep_down;
		(cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_UNLOCK && lockdown_q[blk])
			|=> locked_q[$past(blk)] && lockdown_q[$past(blk)];
	endproperty
	a_keep_down: assert property (p_keep_down) else $error("locked-down block changed");

	property p_lockdown;
		(cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_LOCKDOWN)
			|=> lockdown_q[$past(blk)] && locked_q[$past(blk)];
	endproperty
	a_lockdown: assert property (p_lockdown) else $error("block not locked down");

	property p_prot;
		(cmd_stb && cmd_q == C_PROT)
			|=> prot_addr_q == $past(addr) && prot_data_q == $past(dq_in) && cmd_q == C_IDLE;
	endproperty
	a_prot: assert property (p_prot) else $error("protection write not captured");

	property p_rcr;
		(cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_RCR_SET)
			|=> rcr_q == $past(addr) && rd_q == R_ARRAY;
	endproperty
	a_rcr: assert property (p_rcr) else $error("configuration not stored");

	property p_async_wait;
		rcr_q[`FLCK_RCR_MODE] |=> !wait_out;
	endproperty
	a_async_wait: assert property (p_async_wait) else $error("wait active in page mode");

	property p_page;
		(rcr_q[`FLCK_RCR_MODE] && rd_q == R_ARRAY)
			|=> dq_out == $past(mif.rdata[{addr_lat_q[1:0], 4'h0} +: 16]);
	endproperty
	a_page: assert property (p_page) else $error("wrong page word");

	property p_first_word;
		(beat && b_q == B_LAT) |=> b_q == B_DATA && dq_out == $past(burst_word);
	endproperty
	a_first_word: assert property (p_first_word) else $error("first burst word wrong");

	property p_repeat;
		(beat && rd_q != R_ARRAY) |=> baddr_q == $past(baddr_q);
	endproperty
	a_repeat: assert property (p_repeat) else $error("non-array burst moved");

	// Main scenarios
	c_lockdown: cover property (cmd_stb && cmd_q == C_SETUP60 && code == `FLCK_CMD_LOCKDOWN);
	c_seq_err: cover property (seq_err);
	c_burst_done: cover property (b_q == B_DATA ##1 b_q == B_DONE);
endmodule // flck_top

// ### flck_host.sv
`timescale 1ns/100ps
module flck_host (
	// Clock
	input wire logic mclk,
	// Flash pins driven by the host
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic addr_valid_n,
	output logic flash_clk,
	output logic [15:0] addr,
	output logic [15:0] dq_in
);
	// Idle: deselected, burst clock parked high
	initial begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		addr_valid_n = 1'b0;
		flash_clk = 1'b1;
		addr = 16'h0000;
		dq_in = 16'h5a5a;
	end

	// One command write; taken where the strobe rises
	task automatic cmd(input logic [7:0] code, input logic [15:0] a);
		@(posedge mclk);
		oe_n <= 1'b1;
		ce_n <= 1'b0;
		we_n <= 1'b0;
		addr <= a;
		dq_in <= {8'h00, code};
		@(posedge mclk);
		we_n <= 1'b1;
		@(posedge mclk);
		ce_n <= 1'b1;
		// Released data no longer shows the code
		dq_in <= ~dq_in;
		repeat (2) @(posedge mclk);
	endtask

	// Page read; valid tied low, clock parked high
	task automatic page_rd(input logic [15:0] a);
		@(posedge mclk);
		we_n <= 1'b1;
		addr_valid_n <= 1'b0;
		flash_clk <= 1'b1;
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		addr <= a;
		repeat (6) @(posedge mclk);
	endtask

	// Burst start: valid pulsed low then high, or held low for a clock capture
	task automatic burst_start(input logic [15:0] a, input bit hold);
		@(posedge mclk);
		ce_n <= 1'b1;
		@(posedge mclk);
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		we_n <= 1'b1;
		addr <= a;
		addr_valid_n <= 1'b0;
		repeat (2) @(posedge mclk);
		if (!hold) addr_valid_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	// One valid burst clock edge; slow enough for the mclk sampler
	task automatic clk_edge();
		@(posedge mclk);
		flash_clk <= 1'b0;
		repeat (4) @(posedge mclk);
		flash_clk <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
endmodule // flck_host

// ### flash_lock_config_read_modes_bench.sv
`timescale 1ns/100ps
`include "flck_consts.svh"
module flash_lock_config_read_modes_bench;
	// Clock, reset and APB drive
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	// Design outputs and host pins
	logic [31:0] prdata;
	logic pready, pslverr, dq_oe, wait_out;
	logic [15:0] dq_out, addr, dq_in;
	logic ce_n, oe_n, we_n, addr_valid_n, flash_clk;
	// Reference model: array, lock bits, read state, config, status
	int mem [64];
	int lk, ld, rs, read_config_reg, st, lc, seed, bad_count, num_checks;
	int ops [4] = '{8'hd0, 8'h01, 8'h2f, 8'hd0};
	int rcd [4] = '{8'h70, 8'h90, 8'h98, 8'hff};
	int rsv [4] = '{2, 1, 3, 0};
	logic [31:0] rd_q;
	logic err_q;

	// 250 MHz clock
	always #2 mclk = ~mclk;

	flck_top flck_top_inst (
		.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr_valid_n(addr_valid_n),
		.flash_clk(flash_clk), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.wait_out(wait_out)
	);
	flck_host flck_host_inst (
		.mclk(mclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr_valid_n(addr_valid_n),
		.flash_clk(flash_clk), .addr(addr), .dq_in(dq_in)
	);

	// Verdict, the only exit
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Count a comparison, report a miss
	task automatic tally(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		tally(g === e, $sformatf("register %h expected %h", g, e));
	endtask
	task automatic chk_dq(input logic [15:0] g, input logic [15:0] e);
		tally(g === e, $sformatf("data pins %h expected %h", g, e));
	endtask
	task automatic chk_bit(input logic g, input logic e);
		tally(g === e, $sformatf("flag %b expected %b", g, e));
	endtask

	// APB transfer; held until pready, bounded wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			bad_count++;
			give_verdict();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk_reg(rd_q, e);
	endtask
	// Read-state field only; other fields move with bursts
	task automatic st_chk(input int e);
		apb(1'b0, `FLCK_REG_STATE, 32'h0000_0000);
		chk_reg({30'h0, rd_q[3:2]}, e);
	endtask
	task automatic chk_idle();
		rd_chk(`FLCK_REG_STATUS, st);
		rd_chk(`FLCK_REG_RCR, read_config_reg);
		rd_chk(`FLCK_REG_LOCK, {ld[15:0], lk[15:0]});
		st_chk(rs);
	endtask
	task automatic model_reset();
		lk = 32'h0000_ffff;
		ld = 0;
		rs = 0;
		read_config_reg = 32'h0000_bfcf;
		st = 32'h0000_0080;
	endtask
	// Page read: word, wait and drive enable
	task automatic pg_chk(input logic [15:0] a, input int e);
		flck_host_inst.page_rd(a);
		chk_dq(dq_out, e[15:0]);
		chk_bit(wait_out, 1'b0);
		chk_bit(dq_oe, 1'b1);
	endtask
	// Burst: wait during latency, first word on edge lc, then one per edge
	// Valid held low: first edge is the capture, so all shift by one
	task automatic burst_chk(input int a, input int w0, input bit arr, input bit hold);
		flck_host_inst.burst_start(a[15:0], hold);
		for (int k = 1; k < lc + hold + 4; k++) begin
			flck_host_inst.clk_edge();
			if (k == 1) chk_bit(wait_out, 1'b1);
			if (k >= lc + hold) chk_dq(dq_out, arr ? mem[a + k - lc - hold] : w0);
		end
	endtask

	// Watchdog against hangs
	initial begin
		repeat (100000) @(posedge mclk);
		bad_count++;
		give_verdict();
	end

	// Main sequence
	initial begin
		int a, b, v;
		seed = 50;
		model_reset();
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk_idle();
		// Unmapped offset errors; read-only config ignores writes
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk_bit(err_q, 1'b1);
		chk_reg(rd_q, 32'h0000_0000);
		apb(1'b1, `FLCK_REG_RCR, 32'h0000_0000);
		rd_chk(`FLCK_REG_RCR, read_config_reg);
		// Load the array with random words
		apb(1'b1, `FLCK_REG_MEM_ADDR, 32'h0000_0000);
		for (a = 0; a < 64; a++) begin
			mem[a] = $random(seed) & 32'h0000_ffff;
			apb(1'b1, `FLCK_REG_MEM_DATA, mem[a]);
		end
		for (v = 0; v < 8; v++) begin
			a = $random(seed) & 63;
			pg_chk(a[15:0], mem[a]);
		end
		// Unlock, lock, lock-down, then unlock refused
		for (v = 0; v < 16; v++) begin
			if (v % 4 == 0) b = $random(seed) & 15;
			flck_host_inst.cmd(`FLCK_CMD_LOCK_SETUP, 16'h0000);
			flck_host_inst.cmd(ops[v % 4], 16'(b << 12));
			case (ops[v % 4])
				`FLCK_CMD_LOCK: lk |= 1 << b;
				`FLCK_CMD_UNLOCK: if (!ld[b]) lk &= ~(1 << b);
				default: begin
					lk |= 1 << b;
					ld |= 1 << b;
				end
			endcase
			rd_chk(`FLCK_REG_LOCK, {ld[15:0], lk[15:0]});
		end
		// Wrong code after setup flags a sequence error
		for (v = 0; v < 2; v++) begin
			flck_host_inst.cmd(`FLCK_CMD_LOCK_SETUP, 16'h0000);
			flck_host_inst.cmd(v ? 8'h40 : `FLCK_CMD_READ_ARRAY, 16'h0000);
			chk_bit(dq_oe, 1'b0);
			rd_chk(`FLCK_REG_STATUS, 32'h0000_00b0);
			st_chk(rs);
			// Clear once from software, once by the clear command
			if (v) flck_host_inst.cmd(`FLCK_CMD_CLR_STATUS, 16'h0000);
			else apb(1'b1, `FLCK_REG_STATUS, 32'h0000_0000);
			rd_chk(`FLCK_REG_STATUS, st);
		end
		// Second write of a protection pair is captured
		flck_host_inst.cmd(`FLCK_CMD_PROT_SETUP, 16'h0000);
		flck_host_inst.cmd(8'h5c, 16'h0a3c);
		rd_chk(`FLCK_REG_PROT, 32'h0a3c_005c);
		// Each read state, ending back in array
		for (v = 0; v < 4; v++) begin
			flck_host_inst.cmd(rcd[v], 16'h0000);
			rs = rsv[v];
			st_chk(rs);
			pg_chk(16'h0005, v == 0 ? st : v == 1 ? read_config_reg : v == 2 ? 0 : mem[5]);
		end
		// Configure burst from status state; reads return to array
		lc = 2 + ($unsigned($random(seed)) % 6);
		read_config_reg = (lc << 11) | ($random(seed) & 32'h0000_07ff);
		flck_host_inst.cmd(`FLCK_CMD_READ_STATUS, 16'h0000);
		flck_host_inst.cmd(`FLCK_CMD_LOCK_SETUP, 16'h0000);
		flck_host_inst.cmd(`FLCK_CMD_RCR_SET, read_config_reg[15:0]);
		rd_chk(`FLCK_REG_RCR, read_config_reg);
		st_chk(0);
		a = $random(seed) & 31;
		burst_chk(a, 0, 1'b1, 1'b0);
		flck_host_inst.cmd(`FLCK_CMD_READ_STATUS, 16'h0000);
		burst_chk(0, st, 1'b0, 1'b0);
		// Array burst with valid held low, captured on the first clock edge
		flck_host_inst.cmd(`FLCK_CMD_READ_ARRAY, 16'h0000);
		a = $random(seed) & 31;
		burst_chk(a, 0, 1'b1, 1'b1);
		// Reset in mid-run restores page mode and array state
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		model_reset();
		chk_idle();
		pg_chk(a[15:0], mem[a]);
		give_verdict();
	end
endmodule // flash_lock_config_read_modes_bench
